// [design/touch_conversion_rate_scheduler.sv]
// touch conversion sequencer with rate ticks, readout gating and proximity scans
// What this block does
// - no new conversion until masked data read
// - blocked tick is dropped, retry next tick
// - conversion time follows the 47/21 formula
// - samples per channel are 1,3,5,7
// - converts each enabled channel, one to five
// - bias settle delay 0.5us to 18.19ms
// - refilter settle delay 0.5us to 18.19ms
// - readout interval measured in SCL periods
// - proximity wakes each scan interval, one sample
// - proximity gives 12 bit code via ADC
// - sense electrode selectable
// - guard electrode selectable
// - proximity codes reduced to far/close flag
// - offset compensation tracks environment capacitance
// - pen down detection starts conversion
// - end clears pending flag, line low till read when IRQ_CONV is unmasked
//
// The placing of the registers and the Wishbone register port were decided locally.
`timescale 1ns/10ps
`default_nettype none
module touch_conversion_rate_scheduler
  import tcr_pkg::*;
#(
  parameter int DLY_MAX_P = DLY_MAX_CYC
) (
  input  wire logic             clk_in,                      // 100 MHz oscillator
  input  wire logic             srst_in,                     // sync reset
  input  wire logic             wb_cyc_in,                   // wishbone cycle
  input  wire logic             wb_stb_in,                   // wishbone strobe
  input  wire logic             wb_we_in,                    // write enable
  input  wire logic [7:0]       wb_adr_in,                   // byte address
  input  wire logic [3:0]       wb_sel_in,                   // byte lanes
  input  wire logic [31:0]      wb_dat_in,                   // write data
  output logic      [31:0]      wb_dat_out,                  // read data
  output logic                  wb_ack_out,                  // ack
  input  wire logic             pen_down_in,                 // pen detect pin
  input  wire logic             scl_in,                      // link clock pin
  input  wire logic [ADC_W-1:0] adc_data_in,                 // shared adc result
  output logic                  adc_start_out,               // adc start pulse
  output logic                  adc_prox_out,                // adc owned by proximity
  output logic      [2:0]       adc_chan_out,                // channel under conversion
  output logic                  bias_en_out,                 // channel bias on
  output logic                  sense_electrode_select_out,  // 1 external sensor
  output logic                  guard_electrode_select_out,  // 1 external guard
  output logic                  proximity_flag_out,          // 1 close
  output logic                  conversion_pending_flag_out, // conversion running
  output logic                  interrupt_line_low_out,      // low while data wait
  output logic                  irq_out                      // unmasked status pending
);
  typedef struct packed {
    state_t                    st;
    logic [DLY_W-1:0]          cnt;
    logic [2:0]                chan;
    logic [2:0]                samp;
    logic [ACC_W-1:0]          acc;
    logic [NCH-1:0]            cmask;
    logic [NCH-1:0]            unread;
    logic [NCH-1:0][ACC_W-1:0] data;
    logic                      pend;
    logic                      line;
    logic [2:0]                istat;
    logic [2:0]                imask;
    logic                      irq;
    logic [7:0]                ctrl;
    logic [NCH-1:0]            chmask;
    logic [DLY_W-1:0]          ts0;
    logic [DLY_W-1:0]          ts2;
    logic [RATE_W-1:0]         rate;
    logic [RATE_W-1:0]         pscan;
    logic [ADC_W-1:0]          pthr;
    logic                      preq;
    logic                      comp;
    logic                      flag;
    logic [ADC_W-1:0]          praw;
    logic [ADC_W-1:0]          pavg;
    logic [ADC_W:0]            pdiff;
    logic                      scl_q;
    logic [15:0]               tcnt;
    logic [15:0]               tcom;
    logic                      ack;
    logic [31:0]               rdat;
    logic                      adc_start;
    logic                      adc_prox;
    logic                      bias;
  } regs_t;

  regs_t r, n;
  logic  pen_s, scl_s, touch_tick, prox_tick;

  // first enabled channel at or above a start index, NCH when none
  function automatic logic [2:0] next_chan(input logic [NCH-1:0] m, input logic [3:0] from);
    logic [2:0] res;
    res = 3'(NCH);
    for (int i = NCH - 1; i >= 0; i--) begin
      if (m[i] && 4'(i) >= from) begin
        res = 3'(i);
      end
    end
    return res;
  endfunction

  // byte-lane merge of a write into an old value
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [3:0] sel, input logic [31:0] d);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[8*b +: 8] = d[8*b +: 8];
      end
    end
    return res;
  endfunction

  // delay setting kept inside the programmable range
  function automatic logic [DLY_W-1:0] clamp_dly(input logic [31:0] v);
    logic [DLY_W-1:0] res;
    if (v < 32'(DLY_MIN_CYC)) begin
      res = DLY_W'(DLY_MIN_CYC);
    end else if (v > 32'(DLY_MAX_P)) begin
      res = DLY_W'(DLY_MAX_P);
    end else begin
      res = v[DLY_W-1:0];
    end
    return res;
  endfunction

  // pins cross into the oscillator domain first
  sync2 #(.W(2)) u_sync (
    .clk_in  (clk_in),
    .srst_in (srst_in),
    .d_in    ({pen_down_in, scl_in}),
    .q_out   ({pen_s, scl_s})
  );

  tick_gen #(.W(RATE_W)) u_touch_tick (
    .clk_in    (clk_in),
    .srst_in   (srst_in),
    .reload_in (r.rate),
    .tick_out  (touch_tick)
  );

  tick_gen #(.W(RATE_W)) u_prox_tick (
    .clk_in    (clk_in),
    .srst_in   (srst_in),
    .reload_in (r.pscan),
    .tick_out  (prox_tick)
  );

  // next-state logic for sequencer, proximity path and register file
  always_comb begin
    logic             req, wr, rd;
    logic [31:0]      wv;
    logic [2:0]       nfilt, nc;
    logic [2:0]       iset, iclr;
    logic [ADC_W:0]   dlt;
    logic             blocked;
    n       = r;
    req     = wb_cyc_in && wb_stb_in && !r.ack;
    wr      = req && wb_we_in;
    rd      = req && !wb_we_in;
    wv      = 32'h0;
    nfilt   = {r.ctrl[CTRL_FILT +: 2], 1'b1};
    nc      = 3'h0;
    iset    = 3'h0;
    iclr    = 3'h0;
    dlt     = '0;
    blocked = 1'b0;
    n.adc_start = 1'b0;
    n.ack       = req;
    n.scl_q     = scl_s;
    if (prox_tick) begin
      n.preq = 1'b1;
    end
    // sequencer
    case (r.st)
      S_IDLE: begin
        blocked = r.unread != '0 || r.chmask == '0 || !r.ctrl[CTRL_PEN_TRIGGER];
        if (touch_tick && !blocked) begin
          n.st = S_PENCHK;
        end else if (n.preq) begin
          n.st       = S_PROX;
          n.preq     = 1'b0;
          n.cnt      = DLY_W'(ADC_CYC - 1);
          n.adc_prox = 1'b1;
          n.adc_start = 1'b1;
          n.pend     = 1'b1;
        end
        if (touch_tick && blocked && r.ctrl[CTRL_PEN_TRIGGER]) begin
          iset[IRQ_SKIP] = 1'b1;
        end
      end
      S_PENCHK: begin
        if (pen_s) begin
          n.st    = S_OVH;
          n.cnt   = DLY_W'(OVH_CYC - 2);
          n.cmask = r.chmask;
          n.pend  = 1'b1;
        end else begin
          n.st = S_IDLE;
        end
      end
      S_OVH: begin
        n.cnt = r.cnt - DLY_W'(1);
        if (r.cnt == '0) begin
          n.st   = S_BIAS;
          n.chan = next_chan(r.cmask, 4'h0);
          n.cnt  = r.ts0 - DLY_W'(1);
          n.bias = 1'b1;
          n.acc  = '0;
          n.samp = '0;
        end
      end
      S_BIAS: begin
        n.cnt = r.cnt - DLY_W'(1);
        if (r.cnt == '0) begin
          n.st        = S_SAMPLE;
          n.cnt       = DLY_W'(ADC_CYC - 1);
          n.adc_start = 1'b1;
        end
      end
      S_SAMPLE: begin
        n.cnt = r.cnt - DLY_W'(1);
        if (r.cnt == '0) begin
          n.acc = r.acc + ACC_W'(adc_data_in);
          if (r.samp == nfilt - 3'h1) begin
            n.st  = S_FIN;
            n.cnt = DLY_W'(FIN_CYC - 1);
          end else begin
            n.st   = S_SETTLE;
            n.samp = r.samp + 3'h1;
            n.cnt  = r.ts2 - DLY_W'(1);
          end
        end
      end
      S_SETTLE: begin
        n.cnt = r.cnt - DLY_W'(1);
        if (r.cnt == '0) begin
          n.st        = S_SAMPLE;
          n.cnt       = DLY_W'(ADC_CYC - 1);
          n.adc_start = 1'b1;
        end
      end
      S_FIN: begin
        n.data[r.chan] = r.acc;
        n.bias         = 1'b0; // bias dropped after the last channel, kept on between channels
        nc             = next_chan(r.cmask, 4'(r.chan) + 4'h1);
        if (nc == 3'(NCH)) begin
          n.st     = S_IDLE;
          n.pend   = 1'b0;
          n.unread = r.cmask;
          iset[IRQ_CONV] = 1'b1;
          if (r.imask[IRQ_CONV]) begin
            n.line = 1'b0;
          end
        end else begin
          n.st   = S_BIAS;
          n.chan = nc;
          n.cnt  = r.ts0 - DLY_W'(1);
          n.bias = 1'b1;
          n.acc  = '0;
          n.samp = '0;
        end
      end
      S_PROX: begin
        n.cnt = r.cnt - DLY_W'(1);
        if (r.cnt == '0) begin
          n.st       = S_PPROC;
          n.praw     = adc_data_in;
          n.adc_prox = 1'b0;
        end
      end
      S_PPROC: begin
        // compensation replaces the baseline; tracking freezes while close
        if (r.comp) begin
          n.pavg = r.praw;
          n.comp = 1'b0;
        end else if (!r.flag) begin
          dlt    = {1'b0, r.praw} - {1'b0, r.pavg};
          n.pavg = r.pavg + ADC_W'($signed(dlt) >>> AVG_SHIFT);
        end
        n.pdiff = {1'b0, r.praw} - {1'b0, n.pavg};
        n.flag  = $signed(n.pdiff) > $signed({1'b0, r.pthr});
        if (n.flag != r.flag) begin
          iset[IRQ_PROX] = 1'b1;
        end
        n.pend = 1'b0;
        n.st   = S_IDLE;
      end
      default: begin
        n.st = S_IDLE;
      end
    endcase
    // readout interval in link clock periods
    if (!r.line && scl_s && !r.scl_q) begin
      n.tcnt = r.tcnt + 16'h1;
    end
    if (r.line && !n.line) begin
      n.tcnt = 16'h0;
    end
    // register writes
    if (wr) begin
      case (wb_adr_in)
        OFS_CTRL: begin
          wv     = wmerge({24'h0, r.ctrl}, wb_sel_in, wb_dat_in);
          n.ctrl = wv[7:0];
        end
        OFS_CHMASK: begin
          wv       = wmerge({27'h0, r.chmask}, wb_sel_in, wb_dat_in);
          n.chmask = wv[NCH-1:0];
        end
        OFS_TS0: n.ts0 = clamp_dly(wmerge({11'h0, r.ts0}, wb_sel_in, wb_dat_in));
        OFS_TS2: n.ts2 = clamp_dly(wmerge({11'h0, r.ts2}, wb_sel_in, wb_dat_in));
        OFS_RATE: begin
          wv     = wmerge({8'h0, r.rate}, wb_sel_in, wb_dat_in);
          n.rate = wv[RATE_W-1:0];
        end
        OFS_PSCAN: begin
          wv      = wmerge({8'h0, r.pscan}, wb_sel_in, wb_dat_in);
          n.pscan = wv[RATE_W-1:0];
          if (r.pscan == '0 && wv[RATE_W-1:0] != '0) begin
            n.comp = 1'b1; // startup compensation
          end
        end
        OFS_PTHR: begin
          wv     = wmerge({20'h0, r.pthr}, wb_sel_in, wb_dat_in);
          n.pthr = wv[ADC_W-1:0];
        end
        OFS_ISTAT: iclr = wb_sel_in[0] ? wb_dat_in[2:0] : 3'h0;
        OFS_IMASK: begin
          wv      = wmerge({29'h0, r.imask}, wb_sel_in, wb_dat_in);
          n.imask = wv[2:0];
        end
        default: begin
        end
      endcase
    end
    // register reads; data reads retire their unread bit
    n.rdat = 32'h0;
    if (rd) begin
      case (wb_adr_in)
        OFS_CTRL:   n.rdat = {24'h0, r.ctrl};
        OFS_CHMASK: n.rdat = {27'h0, r.chmask};
        OFS_TS0:    n.rdat = {11'h0, r.ts0};
        OFS_TS2:    n.rdat = {11'h0, r.ts2};
        OFS_RATE:   n.rdat = {8'h0, r.rate};
        OFS_PSCAN:  n.rdat = {8'h0, r.pscan};
        OFS_PTHR:   n.rdat = {20'h0, r.pthr};
        OFS_STAT:   n.rdat = {24'h0, r.unread, r.st != S_IDLE, r.flag, r.pend};
        OFS_ISTAT:  n.rdat = {29'h0, r.istat};
        OFS_IMASK:  n.rdat = {29'h0, r.imask};
        OFS_TCOM:   n.rdat = {16'h0, r.tcom};
        OFS_PROX:   n.rdat = {3'h0, r.pdiff, r.flag, 3'h0, r.praw};
        default: begin
          for (int i = 0; i < NCH; i++) begin
            if (wb_adr_in == OFS_DATA0 + 8'(4 * i)) begin
              n.rdat      = {17'h0, r.data[i]};
              // a result landing in this cycle keeps its unread bit
              if (!iset[IRQ_CONV]) begin
                n.unread[i] = 1'b0;
              end
            end
          end
        end
      endcase
    end
    // line released once every masked channel is read
    if (!r.line && n.unread == '0) begin
      n.line = 1'b1;
      n.tcom = n.tcnt;
    end
    // sticky status: a set in the clearing cycle wins
    n.istat = (r.istat & ~iclr) | iset;
    n.irq   = |(n.istat & n.imask);
  end

  // the whole state registers here
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      r        <= '0;
      r.st     <= S_IDLE;
      r.line   <= 1'b1;
      r.ctrl   <= RST_CTRL;
      r.chmask <= RST_CHMASK;
      r.ts0    <= DLY_W'(DLY_MIN_CYC);
      r.ts2    <= DLY_W'(DLY_MIN_CYC);
      r.pthr   <= RST_PTHR;
      r.imask  <= RST_IMASK;
    end else begin
      r <= n;
    end
  end

  assign wb_dat_out                  = r.rdat;
  assign wb_ack_out                  = r.ack;
  assign adc_start_out               = r.adc_start;
  assign adc_prox_out                = r.adc_prox;
  assign adc_chan_out                = r.chan;
  assign bias_en_out                 = r.bias;
  assign sense_electrode_select_out  = r.ctrl[CTRL_SENSE];
  assign guard_electrode_select_out  = r.ctrl[CTRL_GUARD];
  assign proximity_flag_out          = r.flag;
  assign conversion_pending_flag_out = r.pend;
  assign interrupt_line_low_out      = r.line;
  assign irq_out                     = r.irq;

  // helper: cycles since pen check, and the expected conversion length
  logic [31:0] len_r, exp_len;
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      len_r <= 32'h0;
    end else begin
      len_r <= (r.st == S_PENCHK) ? 32'h1 : len_r + 32'h1;
    end
  end
  always_comb begin
    int nf;
    nf      = 2 * int'(r.ctrl[CTRL_FILT +: 2]) + 1;
    exp_len = 32'(OVH_CYC + $countones(r.cmask) * (int'(r.ts0) + (nf - 1) * int'(r.ts2) + ADC_CYC * nf + 1));
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);

  property p_gate_unread;
    (r.st == S_PENCHK) |-> $past(r.unread) == '0;
  endproperty
  a_gate_unread: assert property (p_gate_unread) else $error("start with unread data");

  property p_skip;
    (r.st == S_IDLE && touch_tick && r.unread != '0 && r.ctrl[CTRL_PEN_TRIGGER]) |=> r.st != S_PENCHK && r.istat[IRQ_SKIP];
  endproperty
  a_skip: assert property (p_skip) else $error("blocked tick not dropped");

  property p_conv_len;
    (r.st == S_FIN && n.st == S_IDLE) |-> len_r + 32'h1 == exp_len;
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");

  property p_samples;
    (r.st == S_SAMPLE) |-> r.samp < {r.ctrl[CTRL_FILT +: 2], 1'b1};
  endproperty
  a_samples: assert property (p_samples) else $error("sample count exceeded");

  property p_unread_set;
    (r.st == S_FIN && n.st == S_IDLE) |=> r.unread == $past(r.cmask) || !r.line;
  endproperty
  a_unread_set: assert property (p_unread_set) else $error("unread mask wrong");

  property p_bias_on;
    (r.st == S_BIAS || r.st == S_SAMPLE || r.st == S_SETTLE) |-> bias_en_out && !adc_prox_out;
  endproperty
  a_bias_on: assert property (p_bias_on) else $error("bias or adc owner wrong");

  property p_settle;
    (r.st == S_SETTLE) |-> r.cnt < r.ts2 && r.ts2 >= DLY_W'(DLY_MIN_CYC);
  endproperty
  a_settle: assert property (p_settle) else $error("settle out of range");

  property p_end_pend;
    (r.st == S_FIN && n.st == S_IDLE && r.imask[IRQ_CONV]) |=> !r.pend && !interrupt_line_low_out;
  endproperty
  a_end_pend: assert property (p_end_pend) else $error("pending not cleared");

  property p_prox_adc;
    $rose(r.st == S_PROX) |-> adc_prox_out [*8];
  endproperty
  a_prox_adc: assert property (p_prox_adc) else $error("prox lost adc");

  property p_rate_zero;
    (r.rate == '0) |=> !touch_tick;
  endproperty
  a_rate_zero: assert property (p_rate_zero) else $error("tick with zero rate");

  c_conv: cover property ((r.st == S_FIN) ##1 !interrupt_line_low_out);
  c_skip: cover property (r.istat[IRQ_SKIP]);
  c_prox: cover property ($rose(r.flag));
endmodule
`default_nettype wire

// [common/tcr_pkg.sv]
// shared constants and types for the touch conversion rate scheduler
package tcr_pkg;
  // oscillator rate and conversion timing
  localparam int CLK_MHZ     = 100;
  localparam int OVH_CYC     = 47;
  localparam int ADC_CYC     = 21;
  localparam int FIN_CYC     = 1;
  localparam int DLY_MIN_NS  = 500;
  localparam int DLY_MAX_NS  = 18_190_000;
  localparam int DLY_MIN_CYC = (DLY_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int DLY_MAX_CYC = (DLY_MAX_NS / 1000) * CLK_MHZ;
  localparam int AVG_SHIFT   = 4;
  // widths
  localparam int NCH    = 5;
  localparam int DLY_W  = 21;
  localparam int RATE_W = 24;
  localparam int ADC_W  = 12;
  localparam int ACC_W  = 15;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_CHMASK = 8'h04;
  localparam logic [7:0] OFS_TS0    = 8'h08;
  localparam logic [7:0] OFS_TS2    = 8'h0C;
  localparam logic [7:0] OFS_RATE   = 8'h10;
  localparam logic [7:0] OFS_PSCAN  = 8'h14;
  localparam logic [7:0] OFS_PTHR   = 8'h18;
  localparam logic [7:0] OFS_STAT   = 8'h1C;
  localparam logic [7:0] OFS_ISTAT  = 8'h20;
  localparam logic [7:0] OFS_IMASK  = 8'h24;
  localparam logic [7:0] OFS_TCOM   = 8'h28;
  localparam logic [7:0] OFS_PROX   = 8'h2C;
  localparam logic [7:0] OFS_DATA0  = 8'h40;
  // field positions
  localparam int CTRL_PEN_TRIGGER = 0;
  localparam int CTRL_FILT        = 1;
  localparam int CTRL_SENSE       = 3;
  localparam int CTRL_GUARD       = 4;
  localparam int IRQ_CONV         = 0;
  localparam int IRQ_PROX         = 1;
  localparam int IRQ_SKIP         = 2;
  localparam int STAT_PEND        = 0;
  localparam int STAT_PROX        = 1;
  localparam int STAT_BUSY        = 2;
  // reset values
  localparam logic [7:0]        RST_CTRL   = 8'h00;
  localparam logic [NCH-1:0]    RST_CHMASK = 5'h03;
  localparam logic [ADC_W-1:0]  RST_PTHR   = 12'h040;
  localparam logic [2:0]        RST_IMASK  = 3'h0;
  // sequencer states
  typedef enum logic [8:0] {
    S_IDLE   = 9'h001,
    S_PENCHK = 9'h002,
    S_OVH    = 9'h004,
    S_BIAS   = 9'h008,
    S_SAMPLE = 9'h010,
    S_SETTLE = 9'h020,
    S_FIN    = 9'h040,
    S_PROX   = 9'h080,
    S_PPROC  = 9'h100
  } state_t;
endpackage

// [design/sync2.sv]
// two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk_in,   // block clock
  input  wire logic         srst_in,  // sync reset
  input  wire logic [W-1:0] d_in,     // async level
  output logic      [W-1:0] q_out     // synced level
);
  logic [W-1:0] meta_r;
  // first stage feeds only the second stage
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      meta_r <= '0;
      q_out  <= '0;
    end else begin
      meta_r <= d_in;
      q_out  <= meta_r;
    end
  end
endmodule
`default_nettype wire

// [design/tick_gen.sv]
// reloadable down counter giving periodic one-cycle ticks
`timescale 1ns/10ps
`default_nettype none
module tick_gen #(
  parameter int W = 24
) (
  input  wire logic         clk_in,    // block clock
  input  wire logic         srst_in,   // sync reset
  input  wire logic [W-1:0] reload_in, // period in cycles, 0 stops
  output logic              tick_out   // one-cycle tick
);
  logic [W-1:0] cnt_r;
  // zero reload parks the counter so no tick escapes
  always_ff @(posedge clk_in) begin
    if (srst_in || reload_in == '0) begin
      cnt_r    <= '0;
      tick_out <= 1'b0;
    end else if (cnt_r == '0) begin
      cnt_r    <= reload_in - W'(1);
      tick_out <= 1'b1;
    end else begin
      cnt_r    <= cnt_r - W'(1);
      tick_out <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// [bench/tcr_host_model.sv]
// host model: link clock runs only inside readout frames
`timescale 1ns/10ps
`default_nettype none
module tcr_host_model (
  input  wire logic line_in, // data-ready line, low in frame
  output logic      scl_out  // link clock, idle high
);
  // 125 ns link clock while the line is low, idle high otherwise
  always begin
    scl_out = 1'b1;
    if (line_in === 1'b0) begin
      #62.5;
      scl_out = 1'b0;
      #62.5;
    end else begin
      @(line_in);
    end
  end
endmodule
`default_nettype wire

// [bench/touch_conversion_rate_scheduler_tb.sv]
// self-checking bench for the touch conversion rate scheduler
`timescale 1ns/10ps
`default_nettype none
module touch_conversion_rate_scheduler_tb;
  import tcr_pkg::*;
  localparam logic [11:0] AV = 12'h123; // constant adc code
  logic        clk_in = 1'b0;
  logic        srst_in = 1'b1;
  logic        cyc = 1'b0;
  logic        we = 1'b0;
  logic        pen = 1'b1;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdat;
  logic [31:0] q;
  logic        ack, scl, start, prox, sense, guard, pend, line, irq, bias, flag;
  logic [2:0]  chan;
  logic [11:0] adc = AV;
  int          err_total = 0;
  int          compares = 0;
  int          tmo = 0;
  int          ns;
  int          np;

  touch_conversion_rate_scheduler #(.DLY_MAX_P(200)) i_touch_conversion_rate_scheduler (
    .clk_in(clk_in), .srst_in(srst_in), .wb_cyc_in(cyc), .wb_stb_in(cyc), .wb_we_in(we),
    .wb_adr_in(adr), .wb_sel_in(4'hF), .wb_dat_in(wd), .wb_dat_out(rdat), .wb_ack_out(ack),
    .pen_down_in(pen), .scl_in(scl), .adc_data_in(adc), .adc_start_out(start), .adc_prox_out(prox),
    .adc_chan_out(chan), .bias_en_out(bias), .sense_electrode_select_out(sense),
    .guard_electrode_select_out(guard), .proximity_flag_out(flag), .conversion_pending_flag_out(pend),
    .interrupt_line_low_out(line), .irq_out(irq));
  tcr_host_model i_tcr_host_model (.line_in(line), .scl_out(scl));

  always #5 clk_in = ~clk_in;

  // a hang ends the run as a mismatch
  always @(posedge clk_in) begin
    tmo <= tmo + 1;
    if (tmo == 40000) begin
      err_total++;
      end_of_test();
    end
  end

  // verdict and end of run
  task automatic end_of_test();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e) begin
      err_total++;
      $display("unexpected %s exp %0h got %0h", nm, e, s);
    end
  endtask

  // classic single cycle; held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    do @(posedge clk_in); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    wb(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask

  // count adc starts and pending cycles over a fixed span
  task automatic watch(input int k);
    ns = 0;
    np = 0;
    repeat (k) begin
      @(posedge clk_in);
      ns += int'(start === 1'b1);
      np += int'(pend === 1'b1);
    end
  endtask

  // length of a busy level and the adc starts inside it
  task automatic span(input bit px);
    do @(posedge clk_in); while ((px ? prox : pend) !== 1'b1);
    ns = 0;
    np = 0;
    while ((px ? prox : pend) === 1'b1) begin
      np++;
      ns += int'(start === 1'b1);
      @(posedge clk_in);
    end
  endtask

  task automatic t_reset();
    chk("line idle", 32'h1, line);
    chk("pending idle", 32'h0, pend);
    rd(OFS_CHMASK, 32'h3, "mask reset");
    rd(OFS_PTHR, 32'h40, "threshold reset");
    wb(1'b1, 8'h3C, 32'hFFFF_FFFF);
    rd(8'h3C, 32'h0, "unmapped");
  endtask

  // read every masked channel; the line is released after the last
  task automatic readall(input logic [4:0] m, input int nf);
    for (int i = 0; i < NCH; i++)
      if (m[i]) rd(8'(OFS_DATA0 + 4 * i), 32'(nf * AV), "channel data");
    @(posedge clk_in);
    chk("line released", 32'h1, line);
  endtask

  // one conversion; ctrl is parked off while mask and delay change
  task automatic conv(input int k, input logic [4:0] m, input int nc, input int t0w, input int t0, input bit rda);
    int nf;
    int lc;
    nf = 2 * k + 1;
    lc = 0;
    for (int i = 0; i < NCH; i++)
      if (m[i]) lc = i;
    wb(1'b1, OFS_CTRL, 32'(2 * k));
    wb(1'b1, OFS_TS0, 32'(t0w));
    wb(1'b1, OFS_CHMASK, {27'h0, m});
    wb(1'b1, OFS_CTRL, 32'(2 * k + 1));
    span(1'b0);
    // pending rises after the single pen check cycle, which the total counts
    chk("conv time", 32'(47 + nc * (t0 + (nf - 1) * 55 + 21 * nf + 1)), 32'(np + 1));
    chk("samples", 32'(nc * nf), ns);
    chk("line low", 32'h0, line);
    chk("bias off", 32'h0, bias);
    chk("last channel", 32'(lc), chan);
    if (rda) readall(m, nf);
  endtask

  // unread data: ticks dropped and flagged; irq mask and clear
  task automatic t_skip(input logic [4:0] m, input int nf);
    wb(1'b1, OFS_ISTAT, 32'h7);
    watch(2200);
    chk("skip starts", 32'h0, ns);
    chk("skip pending", 32'h0, np);
    rd(OFS_ISTAT, 32'h4, "skip flag");
    chk("irq masked", 32'h0, irq);
    wb(1'b1, OFS_IMASK, 32'h7);
    @(posedge clk_in);
    chk("irq set", 32'h1, irq);
    wb(1'b1, OFS_ISTAT, 32'h4);
    @(posedge clk_in);
    chk("irq clear", 32'h0, irq);
    wb(1'b1, OFS_IMASK, 32'h1);
    readall(m, nf);
  endtask

  task automatic t_pen_up();
    pen <= 1'b0;
    watch(2200);
    chk("pen up starts", 32'h0, ns);
    wb(1'b1, OFS_CTRL, 32'h0);
    pen <= 1'b1;
  endtask

  // one 21-cycle proximity sample per interval, idle between
  task automatic t_prox();
    wb(1'b1, OFS_CTRL, 32'h18);
    wb(1'b1, OFS_PSCAN, 32'd300);
    chk("sense ext", 32'h1, sense);
    chk("guard ext", 32'h1, guard);
    span(1'b1);
    chk("prox adc", 32'd21, np);
    chk("prox start", 32'h1, ns);
    @(posedge clk_in);
    chk("prox far", 32'h0, flag);
    watch(250);
    chk("prox idle", 32'h0, ns);
    // a raised code past the threshold must read as close
    adc <= AV + 12'h100;
    span(1'b1);
    @(posedge clk_in);
    chk("prox close", 32'h1, flag);
  endtask

  // reset, then the scenarios in turn
  initial begin
    repeat (20) @(posedge clk_in);
    srst_in <= 1'b0;
    t_reset();
    wb(1'b1, OFS_TS2, 32'd55);
    wb(1'b1, OFS_IMASK, 32'h1);
    wb(1'b1, OFS_RATE, 32'd2000); // slower than conversion plus readout
    conv(0, 5'h03, 2, 20, 50, 1'b1);
    conv(1, 5'h1F, 5, 60, 60, 1'b1);
    conv(3, 5'h04, 1, 300, 200, 1'b0);
    t_skip(5'h04, 7);
    conv(2, 5'h01, 1, 50, 50, 1'b1);
    t_pen_up();
    t_prox();
    end_of_test();
  end
endmodule
`default_nettype wire
